// File: shared/pdl_pkg.sv
package pdl_pkg;
  localparam int unsigned          ADDR_W          = 8;
  localparam int unsigned          DATA_W          = 16;
  localparam logic [ADDR_W-1:0]    PIN_CFG_OFS     = 8'h38;
  localparam logic [ADDR_W-1:0]    LEAK_OFS        = 8'h39;
  localparam logic [ADDR_W-1:0]    PUMP_OFS        = 8'h3A;
  localparam logic [DATA_W-1:0]    PIN_CFG_RST     = 16'h0008;
  localparam logic [DATA_W-1:0]    LEAK_RST        = 16'h0000;
  localparam logic [DATA_W-1:0]    PUMP_RST        = 16'h0000;
  localparam logic [DATA_W-1:0]    UNMAPPED_RDATA  = 16'h0000;
  localparam int unsigned          PIN_IN_BIT      = 5;
  localparam int unsigned          PIN_OUT_BIT     = 4;
  localparam int unsigned          PULLDOWN_BIT    = 3;
  localparam int unsigned          MODE_MSB        = 2;
  localparam int unsigned          MODE_LSB        = 0;
  localparam int unsigned          SRC_LEAK_BIT    = 1;
  localparam int unsigned          SNK_LEAK_BIT    = 0;
  localparam int unsigned          PUMP_BIT        = 0;
  localparam logic [2:0]           MODE_HIZ        = 3'h0;
  localparam logic [2:0]           MODE_OUT        = 3'h1;
  localparam logic [2:0]           MODE_OUT_IN     = 3'h2;
  localparam logic [2:0]           MODE_IN         = 3'h3;
  localparam logic [2:0]           MODE_OFF        = 3'h4;
endpackage : pdl_pkg

// File: core/pdl_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser; first stage is read only by the second
module pdl_sync (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic d,
  output logic      q
);
  logic s1_q;
  logic s1_d;
  logic s2_d;

  always_comb begin
    s1_d = d;
    s2_d = s1_q;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      q    <= 1'b0;
    end else begin
      s1_q <= s1_d;
      q    <= s2_d;
    end
  end
endmodule : pdl_sync

// File: core/pdl_regs.sv
`timescale 1ns/10ps
// Function
// - the pin configuration register resets to 0x0008, pin idle in high impedance with pull-down on.
// - bit 5 of the pin register is read-only and shows the level sensed on the pin in modes 010 and 011, and reads 0 in the other modes.
// - bit 4 is the output level, resets to 0, and sets the driven level in output modes.
// - bit 3 enables the weak pull-down, resets to 1.
// - mode 000 turns the output driver off and the input buffer off.
// - mode 001 drives the output level with the input buffer off.
// - mode 010 drives the output level with the input buffer on, so the level reads back.
// - mode 011 keeps the driver in high impedance and uses the pin as input.
// - mode 100 turns the driver off and the input buffer off.
// - mode values above 100 behave as high impedance.
// - bit 1 of the leakage register enables source-FET leakage compensation, reset 0.
// - bit 0 of the leakage register enables sink-FET leakage compensation, reset 0.
// - bit 0 of the pump register enables the charge pump, reset 0.
// - reserved bits of all three registers read as zero.
module pdl_regs (
  input  wire logic                        clk_sys,
  input  wire logic                        rstn,
  input  wire logic [pdl_pkg::ADDR_W-1:0]  addr,
  input  wire logic [pdl_pkg::DATA_W-1:0]  wdata,
  input  wire logic                        wr_stb,
  input  wire logic                        rd_stb,
  output logic      [pdl_pkg::DATA_W-1:0]  rdata,
  input  wire logic                        pin_i,
  output logic                             pin_o,
  output logic                             pin_oe,
  output logic                             pin_ie,
  output logic                             weak_pulldown_enable,
  output logic                             source_leak_comp_enable,
  output logic                             sink_leak_comp_enable,
  output logic                             pump_enable
);
  logic       rst_s1_q;
  logic       rst_s2_q;
  logic       srst_n;
  logic       pin_sync;

  logic       out_lvl_q, out_lvl_d;
  logic       pd_en_q, pd_en_d;
  logic [2:0] mode_q, mode_d;
  logic       src_q, src_d;
  logic       snk_q, snk_d;
  logic       pump_q, pump_d;
  logic [pdl_pkg::DATA_W-1:0] rdata_d;
  logic       pin_o_d, pin_oe_d, pin_ie_d;
  logic       in_level;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign srst_n = rst_s2_q;

  pdl_sync u_pin_sync (
    .clk_sys (clk_sys),
    .rstn    (srst_n),
    .d       (pin_i),
    .q       (pin_sync)
  );

  // drive/input-buffer decode of the mode field
  function automatic logic [1:0] mode_drive(input logic [2:0] m);
    case (m)
      pdl_pkg::MODE_HIZ:    mode_drive = 2'h0;
      pdl_pkg::MODE_OUT:    mode_drive = 2'h2;
      pdl_pkg::MODE_OUT_IN: mode_drive = 2'h3;
      pdl_pkg::MODE_IN:     mode_drive = 2'h1;
      pdl_pkg::MODE_OFF:    mode_drive = 2'h0;
      default:              mode_drive = 2'h0;
    endcase
  endfunction : mode_drive

  function automatic logic hit(input logic [pdl_pkg::ADDR_W-1:0] a,
                               input logic [pdl_pkg::ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // input buffer off reads low; pull-down would hold an undriven pad low anyway
  assign in_level = pin_ie & pin_sync;

  always_comb begin
    out_lvl_d = out_lvl_q;
    pd_en_d   = pd_en_q;
    mode_d    = mode_q;
    src_d     = src_q;
    snk_d     = snk_q;
    pump_d    = pump_q;
    if (wr_stb && hit(addr, pdl_pkg::PIN_CFG_OFS)) begin
      out_lvl_d = wdata[pdl_pkg::PIN_OUT_BIT];
      pd_en_d   = wdata[pdl_pkg::PULLDOWN_BIT];
      mode_d    = wdata[pdl_pkg::MODE_MSB:pdl_pkg::MODE_LSB];
    end
    if (wr_stb && hit(addr, pdl_pkg::LEAK_OFS)) begin
      src_d = wdata[pdl_pkg::SRC_LEAK_BIT];
      snk_d = wdata[pdl_pkg::SNK_LEAK_BIT];
    end
    if (wr_stb && hit(addr, pdl_pkg::PUMP_OFS)) begin
      pump_d = wdata[pdl_pkg::PUMP_BIT];
    end
    // reserved bits and the input level have no storage, so writes cannot touch them
    rdata_d = pdl_pkg::UNMAPPED_RDATA;
    if (rd_stb) begin
      if (hit(addr, pdl_pkg::PIN_CFG_OFS)) begin
        rdata_d[pdl_pkg::PIN_IN_BIT]                    = in_level;
        rdata_d[pdl_pkg::PIN_OUT_BIT]                   = out_lvl_q;
        rdata_d[pdl_pkg::PULLDOWN_BIT]                  = pd_en_q;
        rdata_d[pdl_pkg::MODE_MSB:pdl_pkg::MODE_LSB]    = mode_q;
      end else if (hit(addr, pdl_pkg::LEAK_OFS)) begin
        rdata_d[pdl_pkg::SRC_LEAK_BIT] = src_q;
        rdata_d[pdl_pkg::SNK_LEAK_BIT] = snk_q;
      end else if (hit(addr, pdl_pkg::PUMP_OFS)) begin
        rdata_d[pdl_pkg::PUMP_BIT] = pump_q;
      end
    end
    {pin_oe_d, pin_ie_d} = mode_drive(mode_d);
    pin_o_d              = out_lvl_d & pin_oe_d;
  end

  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      out_lvl_q <= pdl_pkg::PIN_CFG_RST[pdl_pkg::PIN_OUT_BIT];
      pd_en_q   <= pdl_pkg::PIN_CFG_RST[pdl_pkg::PULLDOWN_BIT];
      mode_q    <= pdl_pkg::PIN_CFG_RST[pdl_pkg::MODE_MSB:pdl_pkg::MODE_LSB];
      src_q     <= pdl_pkg::LEAK_RST[pdl_pkg::SRC_LEAK_BIT];
      snk_q     <= pdl_pkg::LEAK_RST[pdl_pkg::SNK_LEAK_BIT];
      pump_q    <= pdl_pkg::PUMP_RST[pdl_pkg::PUMP_BIT];
      rdata     <= pdl_pkg::UNMAPPED_RDATA;
      pin_o     <= 1'b0;
      pin_oe    <= 1'b0;
      pin_ie    <= 1'b0;
    end else begin
      out_lvl_q <= out_lvl_d;
      pd_en_q   <= pd_en_d;
      mode_q    <= mode_d;
      src_q     <= src_d;
      snk_q     <= snk_d;
      pump_q    <= pump_d;
      rdata     <= rdata_d;
      pin_o     <= pin_o_d;
      pin_oe    <= pin_oe_d;
      pin_ie    <= pin_ie_d;
    end
  end

  // the leakage controls are only meaningful with both digital-output modes disabled; that is software's job
  always_ff @(posedge clk_sys or negedge srst_n) begin
    if (!srst_n) begin
      weak_pulldown_enable    <= 1'b1;
      source_leak_comp_enable <= 1'b0;
      sink_leak_comp_enable   <= 1'b0;
      pump_enable             <= 1'b0;
    end else begin
      weak_pulldown_enable    <= pd_en_d;
      source_leak_comp_enable <= src_d;
      sink_leak_comp_enable   <= snk_d;
      pump_enable             <= pump_d;
    end
  end
endmodule : pdl_regs

// File: dv/pdl_regs_asserts.sv
`timescale 1ns/10ps
module pdl_regs_asserts (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] rdata,
  input wire logic        pin_i,
  input wire logic        pin_o,
  input wire logic        pin_oe,
  input wire logic        pin_ie,
  input wire logic        weak_pulldown_enable,
  input wire logic        source_leak_comp_enable,
  input wire logic        sink_leak_comp_enable,
  input wire logic        pump_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire [2:0] md = wdata[2:0];
  wire [1:0] lk = wdata[1:0];
  wire       ol = wdata[4];
  wire       pd = wdata[3];
  wire       pw = wr_stb && addr == 8'h38;
  wire       lw = wr_stb && addr == 8'h39;
  wire       uw = wr_stb && addr == 8'h3A;
  wire [6:0] st = {pin_o, pin_oe, pin_ie, weak_pulldown_enable, source_leak_comp_enable, sink_leak_comp_enable,
                   pump_enable};
  property p_oe; pw |=> pin_oe == ($past(md) inside {3'h1, 3'h2}); endproperty
  a_oe: assert property (p_oe) else $error("bad pin_oe");
  property p_ie; pw |=> pin_ie == ($past(md) inside {3'h2, 3'h3}); endproperty
  a_ie: assert property (p_ie) else $error("bad pin_ie");
  property p_po; pw |=> pin_o == ($past(ol) && pin_oe); endproperty
  a_po: assert property (p_po) else $error("bad pin_o");
  property p_pd; pw |=> weak_pulldown_enable == $past(pd); endproperty
  a_pd: assert property (p_pd) else $error("bad pulldown");
  property p_lk; lw |=> {source_leak_comp_enable, sink_leak_comp_enable} == $past(lk); endproperty
  a_lk: assert property (p_lk) else $error("bad leak");
  property p_pu; uw |=> pump_enable == $past(lk[0]); endproperty
  a_pu: assert property (p_pu) else $error("bad pump");
  property p_rs;
    rd_stb |=> ($past(addr) == 8'h38 ? rdata[15:6] == 10'h0 :
                $past(addr) == 8'h3A ? rdata[15:1] == 15'h0 : rdata[15:2] == 14'h0);
  endproperty
  a_rs: assert property (p_rs) else $error("bad reserved");
  property p_in; rd_stb && addr == 8'h38 && !pin_ie |=> !rdata[5]; endproperty
  a_in: assert property (p_in) else $error("bad input bit");
  property p_hd; !(pw || lw || uw) |=> $stable(st); endproperty
  a_hd: assert property (p_hd) else $error("outputs moved");
  c_md: cover property (pw && md == 3'h2);
  c_un: cover property (rd_stb && addr == 8'h3B);
  c_lk: cover property (lw && lk == 2'h3);
endmodule : pdl_regs_asserts

// File: dv/tb.sv
`timescale 1ns/10ps
module tb;
  logic        clk_sys = 1'h0, rstn = 1'h0, wr_stb = 1'h0, rd_stb = 1'h0, pin_i = 1'h0, rs = 1'h0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata, q[$];
  logic        pin_o, pin_oe, pin_ie, wpd, slc, klc, pen;
  logic [31:0] sd = 32'h079E5F63;
  int          n_errors = 0, compares = 0, cyc = 0;
  wire [6:0]   outs = {pin_o, pin_oe, pin_ie, wpd, slc, klc, pen};
  always #20 clk_sys = ~clk_sys;
  pdl_regs dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pin_ie(pin_ie), .weak_pulldown_enable(wpd),
    .source_leak_comp_enable(slc), .sink_leak_comp_enable(klc), .pump_enable(pen));
  function automatic logic [31:0] rnd();
    sd ^= sd << 13;
    sd ^= sd >> 17;
    sd ^= sd << 5;
    return sd;
  endfunction : rnd
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'h1;
    @(posedge clk_sys);
    wr_stb <= 1'h0;
  endtask : wr
  // expectation queued before the strobe; the watcher pops it two cycles later
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'h1;
    q.push_back(e);
    @(posedge clk_sys);
    rd_stb <= 1'h0;
  endtask : rd
  always @(posedge clk_sys) begin
    rs <= rd_stb;
    cyc++;
    if (rs) chk("rdata", q.pop_front(), rdata);
    if (cyc > 3000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    logic [31:0] r;
    logic        oe, ie;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'h1;
    repeat (3) @(posedge clk_sys);
    rd(8'h38, 16'h0008);
    rd(8'h39, 16'h0000);
    rd(8'h3A, 16'h0000);
    rd(8'h3B, 16'h0000);
    chk("outs", 16'h0008, {9'h0, outs});
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      oe = i[2:0] inside {3'h1, 3'h2};
      ie = i[2:0] inside {3'h2, 3'h3};
      @(posedge clk_sys);
      pin_i <= r[31];
      wr(8'h38, {r[15:5], i[3], r[3], i[2:0]});
      #1 chk("outs", {9'h0, i[3] & oe, oe, ie, r[3], 3'h0}, {9'h0, outs});
      rd(8'h38, {10'h0, r[31] & ie, i[3], r[3], i[2:0]});
    end
    $display("test modes done");
    wr(8'h38, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      wr(8'h39, r[15:0]);
      wr(8'h3A, r[31:16]);
      wr(8'h3B, 16'hFFFF);
      #1 chk("outs", {13'h0, r[1:0], r[16]}, {9'h0, outs});
      rd(8'h39, {14'h0, r[1:0]});
      rd(8'h3A, {15'h0, r[16]});
    end
    $display("test leak pump done");
    @(posedge clk_sys);
    rstn <= 1'h0;
    #1 chk("outs", 16'h0008, {9'h0, outs});
    repeat (3) @(posedge clk_sys);
    rstn <= 1'h1;
    repeat (3) @(posedge clk_sys);
    rd(8'h38, 16'h0008);
    repeat (3) @(posedge clk_sys);
    $display("test second reset done");
    end_of_test();
  end
endmodule : tb
bind pdl_regs pdl_regs_asserts u_chk (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
  .pin_ie(pin_ie), .weak_pulldown_enable(weak_pulldown_enable), .source_leak_comp_enable(source_leak_comp_enable),
  .sink_leak_comp_enable(sink_leak_comp_enable), .pump_enable(pump_enable));
